/* evr_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module evr_chk
  import evr_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               HSEL,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire logic               HREADY,
  input wire logic [NUM_EVT-1:0] EVENT_IN,
  input wire logic [31:0]        HRDATA,
  input wire logic               HREADYOUT,
  input wire logic               HRESP,
  input wire logic [NUM_IRQ-1:0] IRQ_OUT,
  input wire logic               WAKEUP_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic       tk;
  logic [1:0] quiet_ff;
  // Transfer taken this edge
  assign tk = HSEL && HTRANS[1] && HREADY;
  // Quiet cycles: no bus traffic and steady events, so outputs must settle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) quiet_ff <= 2'h0;
    else if (tk || !$stable(EVENT_IN)) quiet_ff <= 2'h0;
    else quiet_ff <= quiet_ff + 2'(quiet_ff != 2'h3);
  end
  a_resp_okay: assert property (HRESP == HRESP_OKAY) else $error("bad response");
  a_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  a_write_fast: assert property (tk && HWRITE |=> HREADYOUT) else $error("write stalled");
  a_wait_cause: assert property (!HREADYOUT |-> $past(tk && !HWRITE))
    else $error("stray wait");
  a_irq_quiet: assert property (quiet_ff == 2'h3 |-> $stable(IRQ_OUT))
    else $error("irq moved idle");
  a_wake_quiet: assert property (quiet_ff == 2'h3 |-> $stable(WAKEUP_OUT))
    else $error("wake moved idle");
  a_rdata_hold: assert property (quiet_ff == 2'h3 |-> $stable(HRDATA) && HREADYOUT)
    else $error("read data moved");
  a_rst_clear: assert property ($rose(RST_N) |-> IRQ_OUT == 4'h0 && !WAKEUP_OUT)
    else $error("outputs not clear");
endmodule : evr_chk
`default_nettype wire

/* evr_event_router.sv */
// Behaviour
// R01 - Accept 105 event inputs from pins and internal module signals.
// R02 - Each input selects high level, low level, rising or falling edge.
// R03 - Conditioned per-signal result readable in four raw status words.
// R04 - Global enable gates each conditioned event; pending vector readable in four words.
// R05 - Whole pending vector goes to each of five output blocks.
// R06 - Each output: 105-bit mask ANDed with pending, products ORed together.
// R07 - All 525 masked products readable as output pending words.
// R08 - Outputs zero to three drive interrupt controller, which enables each.
// R09 - Output four drives clock generation unit as a wake-up request.
// R10 - All five output lines readable in one output status register.
// R11 - Any event may serve as interrupt, clock-enable or reset source.
// R12 - Watchdog asserts its first match event when count equals match value.
// R13 - Edge events latch until software clears; levels follow sampled input.
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module evr_event_router
  import evr_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  input  wire logic [NUM_EVT-1:0] EVENT_IN,
  output logic      [31:0]        HRDATA,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic      [NUM_IRQ-1:0] IRQ_OUT,
  output logic                    WAKEUP_OUT
);

  // Event path state
  logic [VEC_W-1:0]   evt_in;
  logic [VEC_W-1:0]   prev_ff;
  logic [VEC_W-1:0]   raw_ff;
  logic [VEC_W-1:0]   nxt_raw;
  logic [VEC_W-1:0]   gen_ff;
  logic [VEC_W-1:0]   edge_ff;
  logic [VEC_W-1:0]   pol_ff;
  logic [VEC_W-1:0]   pend;
  logic [VEC_W-1:0]   rise;
  logic [VEC_W-1:0]   fall;
  logic [VEC_W-1:0]   det;
  logic [VEC_W-1:0]   lvl;
  logic [VEC_W-1:0]   raw_clr;
  logic [VEC_W-1:0]   mask_ff [NUM_OUT];
  logic [VEC_W-1:0]   opend   [NUM_OUT];
  logic [NUM_OUT-1:0] out_ff;
  logic [NUM_OUT-1:0] nxt_out;

  // Bus slave state
  evr_bus_st_t        state_ff;
  evr_bus_st_t        nxt_state;
  logic [ADDR_W-1:0]  addr_ff;
  logic [31:0]        hrdata_ff;
  logic [31:0]        rd_data;
  logic               accept;
  logic               wr_en;

  // Size is not decoded: only whole-word transfers are issued
  // Folding the bits keeps the unused port from looking unconnected
  logic               unused_size;
  assign unused_size = ^HSIZE;

  // R01 widen inputs
  // Pad the 105 inputs to four words; the padding never sets anything.
  // Reserved positions are masked again before they reach raw_ff.
  assign evt_in = VEC_W'(EVENT_IN);

  // Address phase taken only while the bus is ready
  // HTRANS bit 1 covers NONSEQ and SEQ; IDLE and BUSY are ignored
  // A burst beat would simply be handled as another single access
  // Writes land at the end of the data phase, when HWDATA is valid
  assign accept = HSEL && HTRANS[1] && HREADY;
  assign wr_en  = (state_ff == ST_WR);

  // Bus state sequencing
  // ST_RD lasts one cycle; HREADY is low there, so no address is taken
  // and a second request can never overlap the read capture
  always_comb begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_RD: begin
        nxt_state = ST_RDOUT;
      end
      ST_IDLE, ST_WR, ST_RDOUT: begin
        if (accept) begin
          nxt_state = HWRITE ? ST_WR : ST_RD;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address latch for the data phase
  // Only the low address bits are kept; upper bits alias the block
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_ff <= 10'h000;
    end else if (accept) begin
      addr_ff <= HADDR[ADDR_W-1:0];
    end
  end

  // One wait state on reads so a write just before is already visible
  // Trade-off: a zero-wait read would put the whole decode tree
  // straight onto HRDATA instead of behind a flip-flop
  assign HREADYOUT = (state_ff != ST_RD);
  assign HRESP     = HRESP_OKAY;
  assign HRDATA    = hrdata_ff;

  // Configuration writes, reserved bits forced to zero
  // Bits 105 and up are not implemented, so they read back as zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gen_ff  <= RST_VEC;
      edge_ff <= RST_VEC;
      pol_ff  <= RST_VEC;
    end else if (wr_en) begin
      for (int w = 0; w < NUM_WORD; w++) begin
        // R04 global enable
        if (addr_ff == OFF_GEN + 10'(w * 4)) begin
          gen_ff[w*32 +: 32] <= HWDATA & VALID_VEC[w*32 +: 32];
        end
        // R02 sensitivity select
        if (addr_ff == OFF_EDGE + 10'(w * 4)) begin
          edge_ff[w*32 +: 32] <= HWDATA & VALID_VEC[w*32 +: 32];
        end
        if (addr_ff == OFF_POL + 10'(w * 4)) begin
          pol_ff[w*32 +: 32] <= HWDATA & VALID_VEC[w*32 +: 32];
        end
      end
    end
  end

  // Per-output mask writes
  // Five masks of four words each; output k sits at a 0x20 stride
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int k = 0; k < NUM_OUT; k++) begin
        mask_ff[k] <= RST_VEC;
      end
    end else if (wr_en) begin
      for (int k = 0; k < NUM_OUT; k++) begin
        for (int w = 0; w < NUM_WORD; w++) begin
          // R06 mask store
          if (addr_ff == OFF_MASK + 10'(k * 32) + 10'(w * 4)) begin
            mask_ff[k][w*32 +: 32] <= HWDATA & VALID_VEC[w*32 +: 32];
          end
        end
      end
    end
  end

  // Write-one-to-clear strobes on the raw words
  // Limitation: clearing a level bit has no effect, it follows its input
  always_comb begin
    raw_clr = RST_VEC;
    for (int w = 0; w < NUM_WORD; w++) begin
      if (wr_en && (addr_ff == OFF_RAW + 10'(w * 4))) begin
        raw_clr[w*32 +: 32] = HWDATA;
      end
    end
  end

  // Input history for edge detection
  // History resets low, so an input already high at release looks like
  // a rising edge on the first clock; edge_ff resets to level mode, so it never latches
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_ff <= RST_VEC;
    end else begin
      prev_ff <= evt_in;
    end
  end

  // R02 polarity and edge
  // Polarity bit set selects high level or rising edge.
  assign rise = evt_in & ~prev_ff;
  assign fall = ~evt_in & prev_ff;
  assign det  = (pol_ff & rise) | (~pol_ff & fall);
  assign lvl  = ~(evt_in ^ pol_ff);

  // R13 latch or follow
  // Detected edge beats a clear in the same cycle, so no edge is lost.
  // Switching a bit from level to edge keeps its current raw value.
  assign nxt_raw = ((edge_ff & ((raw_ff & ~raw_clr) | det))
                   | (~edge_ff & lvl)) & VALID_VEC;

  // R03 raw status
  // One register for both modes; edge_ff picks how each bit updates
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      raw_ff <= RST_VEC;
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  // R04 pending gate
  // Disabled events still show in raw status but never reach an output
  assign pend = raw_ff & gen_ff;

  // R05 fan-out
  // Every output block sees the full pending vector.
  // Products kept per output so that software can read them back.
  always_comb begin
    for (int k = 0; k < NUM_OUT; k++) begin
      // R06 AND then OR
      opend[k]   = pend & mask_ff[k];
      nxt_out[k] = |opend[k];
    end
  end

  // Outputs registered to keep glitches off the interrupt and reset paths
  // The cost is one extra cycle from pending to the output pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_ff <= 5'h00;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // R08 interrupt lines
  // Each line still needs its own enable in the interrupt controller
  assign IRQ_OUT    = out_ff[NUM_IRQ-1:0];
  // R09 wake-up line
  // R11 routing choice
  // Whether an event becomes a clock enable or reset is decided downstream.
  // A level output: high while any routed event stays pending.
  assign WAKEUP_OUT = out_ff[WAKE_IDX];

  // Read decode; unmapped words read as zero
  // Word n of each group holds event bits 32n to 32n+31
  // Later matches win, but the decoded ranges never overlap
  always_comb begin
    rd_data = RST_WORD;
    for (int w = 0; w < NUM_WORD; w++) begin
      // R03 raw readback
      if (addr_ff == OFF_RAW + 10'(w * 4)) begin
        rd_data = raw_ff[w*32 +: 32];
      end
      // R04 pending readback
      if (addr_ff == OFF_PEND + 10'(w * 4)) begin
        rd_data = pend[w*32 +: 32];
      end
      if (addr_ff == OFF_GEN + 10'(w * 4)) begin
        rd_data = gen_ff[w*32 +: 32];
      end
      if (addr_ff == OFF_EDGE + 10'(w * 4)) begin
        rd_data = edge_ff[w*32 +: 32];
      end
      if (addr_ff == OFF_POL + 10'(w * 4)) begin
        rd_data = pol_ff[w*32 +: 32];
      end
      for (int k = 0; k < NUM_OUT; k++) begin
        if (addr_ff == OFF_MASK + 10'(k * 32) + 10'(w * 4)) begin
          rd_data = mask_ff[k][w*32 +: 32];
        end
        // R07 output pending
        if (addr_ff == OFF_OPEND + 10'(k * 32) + 10'(w * 4)) begin
          rd_data = opend[k][w*32 +: 32];
        end
      end
    end
    // R10 output status
    if (addr_ff == OFF_OUT) begin
      rd_data = {27'h000_0000, out_ff};
    end
  end

  // Read data captured during the wait state, held until the next read
  // Holding the old value keeps HRDATA quiet between reads
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hrdata_ff <= RST_WORD;
    end else if (state_ff == ST_RD) begin
      hrdata_ff <= rd_data;
    end
  end

endmodule : evr_event_router

`default_nettype wire

/* evr_event_router_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module evr_event_router_tb;
  import evr_pkg::*;
  logic         CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, WAKEUP_OUT;
  logic         irq_req, wake_req, wdt_match;
  logic [31:0]  HADDR, HWDATA, HRDATA;
  logic [1:0]   HTRANS;
  logic [2:0]   HSIZE;
  logic [3:0]   IRQ_OUT, en_ff;
  logic [103:0] ev_ff;
  int           bad_count, check_count;
  evr_event_router dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .EVENT_IN({wdt_match, ev_ff}), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .IRQ_OUT(IRQ_OUT), .WAKEUP_OUT(WAKEUP_OUT));
  evr_partner far (.clk(CLK), .rst_n(RST_N), .irq_lines(IRQ_OUT), .en(en_ff),
    .wake_line(WAKEUP_OUT), .irq_req(irq_req), .wake_req(wake_req), .wdt_match(wdt_match));
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Address phase held until ready, then data phase held until ready
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HSIZE <= 3'h2;
    HADDR <= {22'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask : xfer
  task wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(HRDATA, e);
    cmp(32'(HRESP), 32'(HRESP_OKAY));
  endtask : rd
  task t_reset;
    cmp(32'(IRQ_OUT), 32'h0);
    cmp(32'(WAKEUP_OUT), 32'h0);
    rd(10'h3FC, 32'h0);
    rd(OFF_OUT, 32'h0);
  endtask : t_reset
  task t_cfg;
    wr(OFF_POL, 32'h9);
    wr(OFF_EDGE, 32'h5);
    wr(OFF_RAW, 32'hF);
    wr(OFF_GEN, 32'h7);
    wr(OFF_MASK, 32'h1);
    wr(OFF_MASK + OUT_STRIDE, 32'h2);
    wr(OFF_MASK + 10'h040, 32'hC);
    wr(OFF_POL + 10'h00C, 32'hFFFF_FFFF);
    rd(OFF_POL + 10'h00C, 32'h1FF);
    wr(OFF_GEN + 10'h00C, 32'h10);
    wr(OFF_MASK + 10'h08C, 32'h10);
    rd(OFF_RAW, 32'hFFFF_FFF2);
    rd(OFF_PEND, 32'h2);
    cmp(32'(IRQ_OUT), 32'h2);
    cmp(32'(irq_req), 32'h0);
  endtask : t_cfg
  task t_edge;
    ev_ff[0] <= 1'b1;
    ev_ff[2] <= 1'b1;
    repeat (3) @(posedge CLK);
    cmp(32'(IRQ_OUT), 32'h3);
    ev_ff[0] <= 1'b0;
    ev_ff[2] <= 1'b0;
    repeat (3) @(posedge CLK);
    cmp(32'(IRQ_OUT), 32'h7);
    cmp(32'(irq_req), 32'h1);
    rd(OFF_OPEND + 10'h040, 32'h4);
    wr(OFF_RAW, 32'h5);
    repeat (2) @(posedge CLK);
    cmp(32'(IRQ_OUT), 32'h2);
  endtask : t_edge
  // level wake-up, disabled event stays raw only
  task t_level;
    ev_ff[100] <= 1'b1;
    ev_ff[3] <= 1'b1;
    repeat (3) @(posedge CLK);
    cmp(32'(wake_req), 32'h1);
    rd(OFF_OUT, 32'h12);
    rd(OFF_RAW, 32'hFFFF_FFFA);
    rd(OFF_PEND, 32'h2);
    rd(OFF_PEND + 10'h00C, 32'h10);
    ev_ff[100] <= 1'b0;
    repeat (3) @(posedge CLK);
    cmp(32'(WAKEUP_OUT), 32'h0);
  endtask : t_level
  // watchdog match routed as a rising edge to output 3
  task t_wdt;
    int n;
    wr(OFF_EDGE + 10'h00C, 32'h100);
    wr(OFF_GEN + 10'h00C, 32'h110);
    wr(OFF_MASK + 10'h06C, 32'h100);
    n = 0;
    while (IRQ_OUT[3] !== 1'b1 && n < 300) begin
      @(posedge CLK);
      n++;
    end
    cmp(32'(IRQ_OUT), 32'hA);
    cmp(32'(irq_req), 32'h1);
    wr(OFF_RAW + 10'h00C, 32'h100);
    repeat (2) @(posedge CLK);
    cmp(32'(IRQ_OUT), 32'h2);
  endtask : t_wdt
  // Mid-run reset clears outputs and configuration
  task t_midrst;
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    cmp(32'(IRQ_OUT), 32'h0);
    cmp(32'(WAKEUP_OUT), 32'h0);
    RST_N <= 1'b1;
    rd(OFF_GEN + 10'h00C, 32'h0);
    rd(OFF_MASK + 10'h020, 32'h0);
    rd(OFF_OUT, 32'h0);
  endtask : t_midrst
  // Free-running clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Main sequence; idle tail lets the quiet checks fire
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    ev_ff = '0;
    en_ff = 4'hC;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset;
    t_cfg;
    t_edge;
    t_level;
    t_wdt;
    t_midrst;
    repeat (6) @(posedge CLK);
    final_report;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    final_report;
  end
endmodule : evr_event_router_tb
bind evr_event_router evr_chk chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .EVENT_IN(EVENT_IN), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ_OUT(IRQ_OUT), .WAKEUP_OUT(WAKEUP_OUT));
`default_nettype wire

/* evr_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module evr_partner #(
  parameter logic [7:0] MATCH_VAL = 8'h40
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] irq_lines,
  input  wire logic [3:0] en,
  input  wire logic       wake_line,
  output logic            irq_req,
  output logic            wake_req,
  output logic            wdt_match
);
  logic [7:0] cnt_ff;
  assign irq_req = |(irq_lines & en);
  assign wake_req = wake_line;
  // match level when count equals match value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 8'h0;
    else cnt_ff <= cnt_ff + 8'h1;
  end
  assign wdt_match = (cnt_ff == MATCH_VAL);
endmodule : evr_partner
`default_nettype wire

/* evr_pkg.sv */
`default_nettype none

package evr_pkg;

  // Event vector geometry
  localparam int NUM_EVT  = 105;
  localparam int NUM_OUT  = 5;
  localparam int NUM_IRQ  = 4;
  localparam int NUM_WORD = 4;
  localparam int VEC_W    = NUM_WORD * 32;
  localparam int ADDR_W   = 10;

  // Output index of the wake-up line
  localparam int WAKE_IDX = 4;

  // Register byte offsets and strides, all word aligned; most offsets start a four-word group
  localparam logic [ADDR_W-1:0] OFF_RAW    = 10'h000;
  localparam logic [ADDR_W-1:0] OFF_PEND   = 10'h010;
  localparam logic [ADDR_W-1:0] OFF_GEN    = 10'h020;
  localparam logic [ADDR_W-1:0] OFF_EDGE   = 10'h030;
  localparam logic [ADDR_W-1:0] OFF_POL    = 10'h040;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 10'h100;
  localparam logic [ADDR_W-1:0] OFF_OPEND  = 10'h200;
  localparam logic [ADDR_W-1:0] OFF_OUT    = 10'h300;
  localparam logic [ADDR_W-1:0] OUT_STRIDE = 10'h020;
  localparam logic [ADDR_W-1:0] WORD_STEP  = 10'h004;

  // Reset values and the implemented-bit map
  localparam logic [VEC_W-1:0] RST_VEC   = 128'h0000;
  localparam logic [VEC_W-1:0] VALID_VEC = 128'h0000_01FF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [31:0]      RST_WORD  = 32'h0000_0000;

  // Bus field codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WR    = 4'b0010,
    ST_RD    = 4'b0100,
    ST_RDOUT = 4'b1000
  } evr_bus_st_t;

endpackage : evr_pkg

`default_nettype wire
